// >>> ebwc_map.svh
// Purpose: Constants for the byte-wide nonvolatile write control block
// Assumes: 8-bit CPU bus, register at its printed offset
// Notes: Timing counts derive from the 40 MHz clock
//
// Overview of operation
// - 8-bit control register, bits 5 and 0, reset zero
// - Hold bit set: next array write is captured
// - Hold bit clear: array serves ordinary reads
// - High-voltage bit drives programming supply switch
// - High-voltage bit sets only with hold set
// - Erased bytes read back as all ones
// - Raised interrupt pin at reset maps boot ROM
// - Array of 15932 bytes, boot ROM 240
`ifndef EBWC_MAP_SVH
`define EBWC_MAP_SVH
`define EBWC_CTRL_ADDR 14'h001c
`define EBWC_HOLD_BIT 5
`define EBWC_HV_BIT 0
`define EBWC_CTRL_RESET 8'h00
`define EBWC_ERASED 8'hff
`define EBWC_ARRAY_BYTES 15932
`define EBWC_BOOT_BYTES 240
`define EBWC_BOOT_LO 14'h3f00
`define EBWC_BOOT_HI 14'h3fef
`define EBWC_ARRAY_LO 14'h0100
`define EBWC_BURN_MIN_MS 4
`define EBWC_CLK_KHZ 40000
`define EBWC_BURN_CYCLES (`EBWC_BURN_MIN_MS * `EBWC_CLK_KHZ)
`endif

// >>> ebwc_pkg.sv
// Purpose: Shared types for the nonvolatile write control block
// Assumes: Constants come from ebwc_map.svh
// Notes: Types only
package ebwc_pkg;
  typedef logic [13:0] ebwc_addr_t;
  typedef logic [7:0] ebwc_byte_t;
  typedef enum logic [1:0] {EBWC_IDLE, EBWC_ARMED, EBWC_HELD} ebwc_state_t;
endpackage

// >>> ebwc_sync.sv
// Purpose: Two-stage synchroniser for a level from a pin
// Assumes: Single clock domain
// Notes: First stage read only by the second
`timescale 1ns/100ps
`default_nettype none
module ebwc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // Level
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else if (clkEn) begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> ebwc_top.sv
// Purpose: Byte-at-a-time programming control for an erasable array
// Assumes: CPU bus strobes one cycle per access on clk
// Notes: Burn timing is owned by software; no timer here
`timescale 1ns/100ps
`default_nettype none
`include "ebwc_map.svh"
module ebwc_top #(
  parameter int ARRAY_BYTES = `EBWC_ARRAY_BYTES,
  parameter int BOOT_BYTES = `EBWC_BOOT_BYTES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  // CPU bus
  input wire ebwc_pkg::ebwc_addr_t cpuAddr,
  input wire ebwc_pkg::ebwc_byte_t cpuWrData,
  input wire logic cpuWr,
  input wire logic cpuRd,
  output ebwc_pkg::ebwc_byte_t cpuRdData,
  // Pins
  input wire logic irqRaised,
  // Array side
  output ebwc_pkg::ebwc_addr_t arrayAddr,
  output ebwc_pkg::ebwc_byte_t arrayWrData,
  output logic arrayLatched,
  output logic supplyOn,
  output logic bootMapped
);
  import ebwc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic hold_q, hold_d, hv_q, hv_d, rstSeen_q, boot_q, irqSync;
  logic [1:0] strapCnt_q;
  ebwc_state_t state_q, state_d;
  ebwc_addr_t capAddr_q;
  ebwc_byte_t capData_q, rdData_q;
  // Array sized by parameter
  // Too big to reset, so a written bit per byte tracks erasure
  ebwc_byte_t mem [0:ARRAY_BYTES-1];
  logic [ARRAY_BYTES-1:0] burnt_q;
  ebwc_byte_t bootRom [0:BOOT_BYTES-1];

  ebwc_sync uSync (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn(irqRaised),
    .syncOut(irqSync)
  );

  ////////////////////////////////////////////////////////////////////
  wire ctrlHit = (cpuAddr == `EBWC_CTRL_ADDR);
  wire ctrlWr = cpuWr && ctrlHit;
  wire bootHit = bootMapped && (cpuAddr >= `EBWC_BOOT_LO) && (cpuAddr <= `EBWC_BOOT_HI);
  wire [13:0] arrIdx = cpuAddr - `EBWC_ARRAY_LO;
  wire arrHit = (cpuAddr >= `EBWC_ARRAY_LO) && (32'(arrIdx) < ARRAY_BYTES) && !bootHit;
  wire [7:0] bootIdx = 8'(cpuAddr - `EBWC_BOOT_LO);
  wire [13:0] capIdx = capAddr_q - `EBWC_ARRAY_LO;
  wire burnDone = hv_q && !hv_d;
  // Capture once hold is registered, even in IDLE before the state reaches ARMED
  wire capWr = cpuWr && arrHit && hold_q && (state_q != EBWC_HELD);
  wire [7:0] ctrlView = {2'b00, hold_q, 4'b0000, hv_q};

  always_comb begin
    hold_d = hold_q;
    hv_d = hv_q;
    if (ctrlWr) begin
      hold_d = cpuWrData[`EBWC_HOLD_BIT];
      hv_d = cpuWrData[`EBWC_HV_BIT] && hold_q;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      EBWC_IDLE: begin
        if (capWr) state_d = EBWC_HELD;
        else if (hold_q) state_d = EBWC_ARMED;
      end
      EBWC_ARMED: begin
        if (!hold_q) state_d = EBWC_IDLE;
        else if (capWr) state_d = EBWC_HELD;
      end
      EBWC_HELD: if (!hold_q) state_d = EBWC_IDLE;
      default: state_d = EBWC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Control bits clear on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= 1'b0;
      hv_q <= 1'b0;
      state_q <= EBWC_IDLE;
    end else if (clkEn) begin
      hold_q <= hold_d;
      hv_q <= hv_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capAddr_q <= 14'h0000;
      capData_q <= 8'h00;
    end else if (clkEn && capWr) begin
      capAddr_q <= cpuAddr;
      capData_q <= cpuWrData;
    end
  end

  // Strap caught after reset release
  // Synchroniser is cleared by reset too, so wait out its two stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapCnt_q <= 2'h0;
      rstSeen_q <= 1'b0;
      boot_q <= 1'b0;
    end else if (clkEn && !rstSeen_q) begin
      strapCnt_q <= strapCnt_q + 2'h1;
      if (strapCnt_q == 2'h2) begin
        rstSeen_q <= 1'b1;
        boot_q <= irqSync;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clkEn && burnDone && 32'(capIdx) < ARRAY_BYTES) begin
      mem[capIdx] <= burnt_q[capIdx] ? (mem[capIdx] & capData_q) : capData_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burnt_q <= '0;
    end else if (clkEn && burnDone && 32'(capIdx) < ARRAY_BYTES) begin
      burnt_q[capIdx] <= 1'b1;
    end
  end

  // Boot ROM holds 8'h9d in every byte
  generate
    for (genvar i = 0; i < BOOT_BYTES; i++) begin : gBoot
      assign bootRom[i] = 8'h9d;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Array reads only when not held; control and boot reads always
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (clkEn && cpuRd) begin
      if (ctrlHit) begin
        rdData_q <= ctrlView;
      end else if (bootHit && 32'(bootIdx) < BOOT_BYTES) begin
        rdData_q <= bootRom[bootIdx];
      end else if (arrHit && !hold_q) begin
        rdData_q <= burnt_q[arrIdx] ? mem[arrIdx] : `EBWC_ERASED;
      end else begin
        rdData_q <= `EBWC_ERASED;
      end
    end
  end

  assign cpuRdData = rdData_q;
  assign arrayAddr = capAddr_q;
  assign arrayWrData = capData_q;
  assign arrayLatched = hold_q;
  assign supplyOn = hv_q;
  assign bootMapped = boot_q;

  ////////////////////////////////////////////////////////////////////
  AST_HV_NEEDS_HOLD: assert property (@(posedge clk) disable iff (rst)
    $rose(hv_q) |-> $past(hold_q)) else $error("Supply set without hold");
  AST_REFUSED_HV: assert property (@(posedge clk) disable iff (rst)
    (clkEn && ctrlWr && !hold_q) |=> !hv_q) else $error("Refused set took effect");
  AST_SUPPLY: assert property (@(posedge clk) disable iff (rst)
    (clkEn && ctrlWr && hold_q && cpuWrData[`EBWC_HV_BIT]) |=> supplyOn)
    else $error("Supply not connected");
  AST_HV_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (clkEn && ctrlWr && !cpuWrData[`EBWC_HV_BIT]) |=> !supplyOn)
    else $error("Supply not disconnected");
  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (rst)
    (clkEn && cpuRd && ctrlHit) |=> (cpuRdData[7:6] == 2'b00 && cpuRdData[4:1] == 4'h0))
    else $error("Unused control bits nonzero");
  AST_CAPTURE: assert property (@(posedge clk) disable iff (rst)
    (clkEn && capWr) |=> (arrayAddr == $past(cpuAddr)))
    else $error("Held write not captured");
  AST_CAPTURE_DATA: assert property (@(posedge clk) disable iff (rst)
    (clkEn && capWr) |=> (arrayWrData == $past(cpuWrData)))
    else $error("Held data not captured");
  AST_CAPTURE_ONCE: assert property (@(posedge clk) disable iff (rst)
    (clkEn && state_q == EBWC_HELD) |=> $stable(arrayAddr))
    else $error("Second write overwrote capture");
  AST_HELD_READ: assert property (@(posedge clk) disable iff (rst)
    (clkEn && cpuRd && arrHit && !ctrlHit && hold_q) |=> cpuRdData == 8'hff)
    else $error("Array read while held");
  AST_ERASED: assert property (@(posedge clk) disable iff (rst)
    (clkEn && cpuRd && arrHit && !hold_q && !burnt_q[arrIdx]) |=> cpuRdData == 8'hff)
    else $error("Erased byte not ones");
  AST_BURN_COMMIT: assert property (@(posedge clk) disable iff (rst)
    (clkEn && burnDone && 32'(capIdx) < ARRAY_BYTES) |=> burnt_q[capIdx])
    else $error("Burn not committed");
  AST_HOLD_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (clkEn && ctrlWr && !cpuWrData[`EBWC_HOLD_BIT]) |=> !arrayLatched)
    else $error("Hold bit not released");
  AST_BOOT_END: assert property (@(posedge clk) disable iff (rst)
    (clkEn && cpuRd && cpuAddr > `EBWC_BOOT_HI) |=> cpuRdData == 8'hff)
    else $error("Read past boot range not erased");
  AST_BOOT_STABLE: assert property (@(posedge clk) disable iff (rst)
    rstSeen_q && $past(rstSeen_q) |-> $stable(bootMapped)) else $error("Boot map changed");
endmodule
`default_nettype wire

// >>> ebwc_array_model.sv
// Purpose: Far-side model of the array and its supply switch
// Assumes: A burn commits as the supply falls
// Notes: Flags supply seen without hold
`timescale 1ns/100ps
`default_nettype none
module ebwc_array_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Array side
  input wire ebwc_pkg::ebwc_addr_t arrayAddr,
  input wire ebwc_pkg::ebwc_byte_t arrayWrData,
  input wire logic arrayLatched,
  input wire logic supplyOn,
  // Observations
  output ebwc_pkg::ebwc_byte_t burnData,
  output logic badSupply
);
  import ebwc_pkg::*;
  logic supplyOn_q;
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supplyOn_q <= 1'b0;
      burnData <= 8'hff;
      badSupply <= 1'b0;
    end else begin
      supplyOn_q <= supplyOn;
      if (supplyOn_q && !supplyOn) begin
        burnData <= burnData & arrayWrData;
      end
      if (supplyOn && !arrayLatched) begin
        badSupply <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> ebwc_top_tb.sv
// Purpose: Self-checking bench for the write control block
// Assumes: One strobe per access, effects after the taken edge
// Notes: Burn wait shortened; timing is software-owned
`timescale 1ns/100ps
`default_nettype none
module ebwc_top_tb;
  import ebwc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cpuWr = 1'b0;
  logic cpuRd = 1'b0;
  logic irqRaised = 1'b0;
  logic clkEn = 1'b1;
  ebwc_addr_t cpuAddr = 14'h0000;
  ebwc_byte_t cpuWrData = 8'h00;
  ebwc_byte_t cpuRdData, arrayWrData, burnData;
  ebwc_addr_t arrayAddr;
  logic arrayLatched, supplyOn, bootMapped, badSupply;
  int bad_count = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  ebwc_top uut (.clk(clk), .rst(rst), .clkEn(clkEn), .cpuAddr(cpuAddr),
    .cpuWrData(cpuWrData), .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuRdData(cpuRdData),
    .irqRaised(irqRaised), .arrayAddr(arrayAddr), .arrayWrData(arrayWrData),
    .arrayLatched(arrayLatched), .supplyOn(supplyOn), .bootMapped(bootMapped));
  ebwc_array_model far (.clk(clk), .rst(rst), .arrayAddr(arrayAddr),
    .arrayWrData(arrayWrData), .arrayLatched(arrayLatched), .supplyOn(supplyOn),
    .burnData(burnData), .badSupply(badSupply));
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input ebwc_addr_t a, input ebwc_byte_t d);
    @(posedge clk);
    cpuAddr <= a;
    cpuWrData <= d;
    cpuWr <= 1'b1;
    @(posedge clk);
    cpuWr <= 1'b0;
    #1;
  endtask
  // Data stands until next read, so one spare edge is safe
  task rd(input ebwc_addr_t a, input ebwc_byte_t e);
    @(posedge clk);
    cpuAddr <= a;
    cpuRd <= 1'b1;
    @(posedge clk);
    cpuRd <= 1'b0;
    @(posedge clk);
    #1;
    chk(14'(cpuRdData), 14'(e));
  endtask
  task complete_run;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task t_reset;
    chk(14'(arrayLatched), 14'h0000);
    chk(14'(bootMapped), 14'h0000);
    rd(14'h001c, 8'h00);
    rd(14'h3f00, 8'hff);
    wr(14'h001c, 8'h01);
    chk(14'(supplyOn), 14'h0000);
    rd(14'h001c, 8'h00);
    $display("test reset done");
  endtask
  // Enable low must swallow a control write
  task t_freeze;
    @(posedge clk);
    clkEn <= 1'b0;
    wr(14'h001c, 8'h20);
    chk(14'(arrayLatched), 14'h0000);
    @(posedge clk);
    clkEn <= 1'b1;
    $display("test freeze done");
  endtask
  task t_burn;
    wr(14'h001c, 8'h20);
    chk(14'(arrayLatched), 14'h0001);
    rd(14'h001c, 8'h20);
    wr(14'h0200, 8'h5a);
    wr(14'h0300, 8'h66);
    chk(arrayAddr, 14'h0200);
    chk(14'(arrayWrData), 14'h005a);
    rd(14'h0200, 8'hff);
    wr(14'h001c, 8'h21);
    chk(14'(supplyOn), 14'h0001);
    rd(14'h001c, 8'h21);
    wr(14'h001c, 8'h20);
    chk(14'(supplyOn), 14'h0000);
    wr(14'h001c, 8'h00);
    chk(14'(burnData), 14'h005a);
    rd(14'h0200, 8'h5a);
    rd(14'h0201, 8'hff);
    chk(14'(badSupply), 14'h0000);
    $display("test burn done");
  endtask
  task t_boot;
    @(posedge clk);
    irqRaised <= 1'b1;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(14'(bootMapped), 14'h0001);
    rd(14'h3f00, 8'h9d);
    rd(14'h3fef, 8'h9d);
    rd(14'h3ff0, 8'hff);
    rd(14'h001c, 8'h00);
    $display("test boot done");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_freeze;
    t_burn;
    t_boot;
    complete_run;
  end
  // Run needs about 71 cycles
  initial begin
    #20000;
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
